// ### bcc_map.vh
// Register map, field positions, reset values and timing counts
// Assumes inclusion by the clock-calendar design files and bench only
`ifndef BCC_MAP_VH
`define BCC_MAP_VH
// ****************************************************************
// Register byte offsets (companions at +0x4 clr, +0x8 set, +0xC inv)
// ****************************************************************
`define BCC_CTRL_OFS 12'h200
`define BCC_ALRM_OFS 12'h210
`define BCC_TIME_OFS 12'h220
`define BCC_DATE_OFS 12'h230
`define BCC_ATIME_OFS 12'h240
`define BCC_ADATE_OFS 12'h250
`define BCC_OP_WR 2'h0
`define BCC_OP_CLR 2'h1
`define BCC_OP_SET 2'h2
`define BCC_OP_INV 2'h3
// ****************************************************************
// Control register fields
// ****************************************************************
`define BCC_CAL_LSB 16
`define BCC_ON_BIT 15
`define BCC_IDLE_BIT 13
`define BCC_PSEL_BIT 7
`define BCC_OSC_BIT 6
`define BCC_UNLOCK_BIT 3
`define BCC_GUARD_BIT 2
`define BCC_HALF_BIT 1
`define BCC_OE_BIT 0
`define BCC_CTRL_WMASK 32'h03FF_A089
// ****************************************************************
// Alarm control fields
// ****************************************************************
`define BCC_ARM_BIT 15
`define BCC_CHIME_BIT 14
`define BCC_PIV_BIT 13
`define BCC_AGUARD_BIT 12
`define BCC_IVL_LSB 8
`define BCC_ALRM_WMASK 32'h0000_EFFF
// ****************************************************************
// Value register writable bits (legal digit widths only)
// ****************************************************************
`define BCC_TIME_WMASK 32'h3F7F_7F00
`define BCC_DATE_WMASK 32'hFF1F_3F07
`define BCC_ADATE_WMASK 32'h001F_3F07
`define BCC_TIME_RST 32'h0000_0000
`define BCC_DATE_RST 32'h0001_0100
// ****************************************************************
// Timing
// ****************************************************************
`define BCC_XTAL_HALF 16384
`define BCC_GUARD_CNT 32
`define BCC_OSC_TIMEOUT 12'h800
`endif

// ### bcc_tick.v
// Crystal prescaler: half and one second ticks with per-minute trim
// Assumes a free crystal clock on a pin, slower than clk_sys / 4
`timescale 1ns/1ps
`default_nettype none
`include "bcc_map.vh"
module bcc_tick #(
  parameter HALF_CNT = `BCC_XTAL_HALF
) (
  // System
  input wire clk_sys,
  input wire nrst,
  // Crystal pin and control
  input wire xtal_clk,
  input wire run,
  input wire restart,
  input wire min_mark,
  input wire [9:0] cal,
  // Status and ticks
  output reg half_tick,
  output reg sec_tick,
  output reg half_flag,
  output reg near_roll,
  output reg osc_running
);
  localparam integer TERM_I = HALF_CNT - 1;
  localparam integer GUARD_I = HALF_CNT - `BCC_GUARD_CNT;
  localparam signed [16:0] TERM = TERM_I[16:0];
  localparam signed [16:0] GUARD = GUARD_I[16:0];
  reg s1_q, s2_q, s3_q, pend_q;
  reg signed [16:0] cnt_q;
  reg [11:0] idle_q;
  wire edge_w = s2_q & ~s3_q;
  always @(posedge clk_sys) begin
    s1_q <= xtal_clk;
    s2_q <= s1_q;
    s3_q <= s2_q;
  end
  always @(posedge clk_sys) begin
    if (!nrst) begin
      cnt_q <= 17'sd0;
      pend_q <= 1'b0;
      half_flag <= 1'b0;
      half_tick <= 1'b0;
      sec_tick <= 1'b0;
      near_roll <= 1'b0;
      idle_q <= 12'h000;
      osc_running <= 1'b0;
    end else begin
      half_tick <= 1'b0;
      sec_tick <= 1'b0;
      idle_q <= edge_w ? 12'h000 : (idle_q == `BCC_OSC_TIMEOUT ? idle_q : idle_q + 12'h001);
      osc_running <= (idle_q != `BCC_OSC_TIMEOUT);
      near_roll <= run & half_flag & (cnt_q >= GUARD);
      if (min_mark)
        pend_q <= 1'b1;
      if (restart) begin
        cnt_q <= 17'sd0;
        half_flag <= 1'b0;
      end else if (run && edge_w) begin
        if (cnt_q >= TERM) begin
          // Trim once a minute: preload shortens or stretches the half second
          cnt_q <= pend_q ? {{7{cal[9]}}, cal} : 17'sd0;
          pend_q <= 1'b0;
          half_flag <= ~half_flag;
          half_tick <= 1'b1;
          sec_tick <= half_flag;
        end else begin
          cnt_q <= cnt_q + 17'sd1;
        end
      end
    end
  end
endmodule // bcc_tick
`default_nettype wire

// ### bcc_date_adv.v
// Combinational one-second advance of BCD time and date
// Assumes legal BCD input; years 2000 to 2099
`timescale 1ns/1ps
`default_nettype none
module bcc_date_adv (
  // Current value
  input wire [31:0] time_i,
  input wire [31:0] date_i,
  // Next value
  output reg [31:0] time_o,
  output reg [31:0] date_o
);
  reg [7:0] mdays;
  reg leap;
  always @* begin
    leap = date_i[28] ? (date_i[27:24] == 4'h2 || date_i[27:24] == 4'h6)
                      : (date_i[27:24] == 4'h0 || date_i[27:24] == 4'h4 ||
                         date_i[27:24] == 4'h8);
    case (date_i[23:16])
      8'h02: mdays = leap ? 8'h29 : 8'h28;
      8'h04, 8'h06, 8'h09, 8'h11: mdays = 8'h30;
      default: mdays = 8'h31;
    endcase
    time_o = time_i;
    date_o = date_i;
    // Seconds, minutes, hours ripple in BCD
    if (time_i[11:8] != 4'h9) time_o[11:8] = time_i[11:8] + 4'h1;
    else begin
      time_o[11:8] = 4'h0;
      if (time_i[15:12] != 4'h5) time_o[15:12] = time_i[15:12] + 4'h1;
      else begin
        time_o[15:12] = 4'h0;
        if (time_i[19:16] != 4'h9) time_o[19:16] = time_i[19:16] + 4'h1;
        else begin
          time_o[19:16] = 4'h0;
          if (time_i[23:20] != 4'h5) time_o[23:20] = time_i[23:20] + 4'h1;
          else begin
            time_o[23:20] = 4'h0;
            if (time_i[31:24] == 8'h23) begin
              time_o[31:24] = 8'h00;
              date_o[3:0] = (date_i[3:0] >= 4'h6) ? 4'h0 : date_i[3:0] + 4'h1;
              if (date_i[15:8] >= mdays) begin
                date_o[15:8] = 8'h01;
                if (date_i[23:16] == 8'h12) begin
                  date_o[23:16] = 8'h01;
                  if (date_i[27:24] != 4'h9) date_o[27:24] = date_i[27:24] + 4'h1;
                  else begin
                    date_o[27:24] = 4'h0;
                    date_o[31:28] = (date_i[31:28] == 4'h9) ? 4'h0 : date_i[31:28] + 4'h1;
                  end
                end else if (date_i[19:16] == 4'h9) date_o[23:16] = 8'h10;
                else date_o[19:16] = date_i[19:16] + 4'h1;
              end else if (date_i[11:8] == 4'h9) begin
                date_o[11:8] = 4'h0;
                date_o[15:12] = date_i[15:12] + 4'h1;
              end else date_o[11:8] = date_i[11:8] + 4'h1;
            end else if (time_i[27:24] == 4'h9) begin
              time_o[27:24] = 4'h0;
              time_o[31:28] = time_i[31:28] + 4'h1;
            end else time_o[27:24] = time_i[27:24] + 4'h1;
          end
        end
      end
    end
  end
endmodule // bcc_date_adv
`default_nettype wire

// ### bcc_top.v
// Clock-calendar unit with alarm, AXI4-Lite register slave, output pin
// Assumes nrst is the power-on reset; crystal arrives on an async pin
`timescale 1ns/1ps
`default_nettype none
`include "bcc_map.vh"
// Operation
// - Signed ten-bit trim adds or removes that many crystal pulses each minute.
// - Module-on bit enables the unit; writable only while value writes are unlocked.
// - Idle halt set stops bus access to the unit while the processor idles.
// - Pin source select picks seconds clock when set, alarm pulse when clear.
// - Pin is driven only while pin output enable is set.
// - Read-only flag shows whether the crystal clock is running.
// - Time and date registers accept writes only while unlocked.
// - Unlock bit sets only after the system write-enable sequence.
// - Rollover guard flag warns that values may change during a read.
// - Half-second flag shows second half; cleared on seconds write.
// - Alarm fires repeat count plus one times.
// - Repeat count decrements per event; wraps to 0xFF only in chime mode.
// - Arm bit clears on event with zero count and chime off.
// - Control and alarm control reset only on power-on reset.
// - Companion addresses at +4, +8, +C clear, set or invert bits.
// - Time kept in 24-hour BCD, years 2000 to 2099, with leap years.
// - Alarm intervals from half second up to one year.
// - Half and one second ticks come from the 32.768 kHz crystal.
// - Digit fields are masked to their legal bit widths, not their legal ranges.
module bcc_top #(
  parameter HALF_CNT = `BCC_XTAL_HALF
) (
  // Clock and power-on reset
  input wire clk_sys,
  input wire nrst,
  // AXI4-Lite write address
  input wire [11:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  // AXI4-Lite write data
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  // AXI4-Lite write response
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // AXI4-Lite read address
  input wire [11:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  // AXI4-Lite read data
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // System status
  input wire cpu_idle,
  input wire wr_seq_ok,
  // Crystal and output pin
  input wire xtal_clk,
  output reg rtc_pin_o,
  output reg rtc_pin_oe,
  output reg alarm_event
);
  localparam [3:0] IVL_HALF = 4'h0;
  localparam [3:0] IVL_SEC = 4'h1;
  localparam [3:0] IVL_10SEC = 4'h2;
  localparam [3:0] IVL_MIN = 4'h3;
  localparam [3:0] IVL_10MIN = 4'h4;
  localparam [3:0] IVL_HOUR = 4'h5;
  localparam [3:0] IVL_DAY = 4'h6;
  localparam [3:0] IVL_WEEK = 4'h7;
  localparam [3:0] IVL_MONTH = 4'h8;
  localparam [3:0] IVL_YEAR = 4'h9;
  localparam [1:0] OKAY = 2'b00;
  localparam [1:0] SLVERR = 2'b10;

  // ****************************************************************
  // State
  // ****************************************************************
  reg [9:0] cal_q;
  reg on_q, idle_halt_q, psel_q, unlock_q, oe_q;
  reg arm_q, chime_q, piv_q, pulse_q;
  reg [3:0] ivl_q;
  reg [7:0] rpt_q;
  reg [31:0] time_q, date_q, atime_q, adate_q;
  reg aw_full_q, w_full_q, chk_q;
  reg [11:0] aw_addr_q;
  reg [31:0] w_data_q;
  reg [3:0] w_strb_q;
  wire half_tick, sec_tick, half_flag, near_roll, osc_running;
  wire [31:0] time_nx, date_nx;

  // ****************************************************************
  // Bus gating and register views
  // ****************************************************************
  wire bus_on = ~(idle_halt_q & cpu_idle);
  assign s_axi_awready = bus_on & ~aw_full_q & ~s_axi_bvalid;
  assign s_axi_wready = bus_on & ~w_full_q & ~s_axi_bvalid;
  assign s_axi_arready = bus_on & ~s_axi_rvalid;
  wire do_wr = aw_full_q & w_full_q & ~s_axi_bvalid;
  wire aguard = on_q & near_roll;
  wire [31:0] ctrl_rd = {6'h00, cal_q, on_q, 1'b0, idle_halt_q, 5'h00, psel_q,
                         osc_running, 2'b00, unlock_q, near_roll, half_flag, oe_q};
  wire [31:0] alrm_rd = {16'h0000, arm_q, chime_q, piv_q, aguard, ivl_q, rpt_q};

  function [31:0] reg_view;
    input [11:0] a;
    begin
      case ({a[11:4], 4'h0})
        `BCC_CTRL_OFS: reg_view = ctrl_rd;
        `BCC_ALRM_OFS: reg_view = alrm_rd;
        `BCC_TIME_OFS: reg_view = time_q;
        `BCC_DATE_OFS: reg_view = date_q;
        `BCC_ATIME_OFS: reg_view = atime_q;
        `BCC_ADATE_OFS: reg_view = adate_q;
        default: reg_view = 32'h0000_0000;
      endcase
    end
  endfunction

  function mapped;
    input [11:0] a;
    begin
      mapped = (a[11:8] == 4'h2) && (a[7:4] <= 4'h5) && (a[1:0] == 2'b00);
    end
  endfunction

  // Plain write or clear/set/invert through a mask of writable bits
  function [31:0] apply;
    input [31:0] old;
    input [31:0] din;
    input [1:0] op;
    input [31:0] msk;
    begin
      case (op)
        `BCC_OP_CLR: apply = old & ~(din & msk);
        `BCC_OP_SET: apply = old | (din & msk);
        `BCC_OP_INV: apply = old ^ (din & msk);
        default: apply = (old & ~msk) | (din & msk);
      endcase
    end
  endfunction

  wire [31:0] lanes = {{8{w_strb_q[3]}}, {8{w_strb_q[2]}}, {8{w_strb_q[1]}},
                       {8{w_strb_q[0]}}};
  wire [1:0] wop = aw_addr_q[3:2];
  wire [11:0] wbase = {aw_addr_q[11:4], 4'h0};
  wire wr_ok = do_wr & mapped(aw_addr_q);
  wire wr_ctrl = wr_ok & (wbase == `BCC_CTRL_OFS);
  wire wr_alrm = wr_ok & (wbase == `BCC_ALRM_OFS);
  wire wr_time = wr_ok & (wbase == `BCC_TIME_OFS) & unlock_q;
  wire wr_date = wr_ok & (wbase == `BCC_DATE_OFS) & unlock_q;
  wire [31:0] ctrl_nx = apply(ctrl_rd, w_data_q, wop, `BCC_CTRL_WMASK & lanes);
  wire [31:0] alrm_nx = apply(alrm_rd, w_data_q, wop, `BCC_ALRM_WMASK & lanes);
  wire sec_wr = wr_time & w_strb_q[1];

  // ****************************************************************
  // Prescaler and calendar advance
  // ****************************************************************
  wire min_mark = on_q & sec_tick & (time_nx[15:8] == 8'h00);
  bcc_tick #(.HALF_CNT(HALF_CNT)) u_tick (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .xtal_clk(xtal_clk),
    .run(on_q),
    .restart(sec_wr),
    .min_mark(min_mark),
    .cal(cal_q),
    .half_tick(half_tick),
    .sec_tick(sec_tick),
    .half_flag(half_flag),
    .near_roll(near_roll),
    .osc_running(osc_running)
  );
  bcc_date_adv u_adv (
    .time_i(time_q),
    .date_i(date_q),
    .time_o(time_nx),
    .date_o(date_nx)
  );

  // ****************************************************************
  // Alarm compare
  // ****************************************************************
  reg [31:0] tmask, dmask;
  always @* begin
    tmask = 32'h0000_0000;
    dmask = 32'h0000_0000;
    case (ivl_q)
      IVL_10SEC: tmask = 32'h0000_0F00;
      IVL_MIN: tmask = 32'h0000_FF00;
      IVL_10MIN: tmask = 32'h000F_FF00;
      IVL_HOUR: tmask = 32'h00FF_FF00;
      IVL_DAY: tmask = 32'hFFFF_FF00;
      IVL_WEEK: begin
        tmask = 32'hFFFF_FF00;
        dmask = 32'h0000_000F;
      end
      IVL_MONTH: begin
        tmask = 32'hFFFF_FF00;
        dmask = 32'h0000_FF00;
      end
      IVL_YEAR: begin
        tmask = 32'hFFFF_FF00;
        dmask = 32'h00FF_FF00;
      end
      default: tmask = 32'h0000_0000;
    endcase
  end
  // Compare one cycle after the tick so the advanced time is seen
  reg tick_d_q, htick_d_q;
  wire ivl_legal = (ivl_q <= IVL_YEAR);
  wire fire = arm_q & on_q & ivl_legal &
              ((ivl_q == IVL_HALF) ? htick_d_q : tick_d_q & (ivl_q != IVL_HALF)) &
              (((time_q ^ atime_q) & tmask) == 32'h0000_0000) &
              (((date_q ^ adate_q) & dmask) == 32'h0000_0000);

  // ****************************************************************
  // AXI4-Lite channels
  // ****************************************************************
  always @(posedge clk_sys) begin
    if (!nrst) begin
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      aw_addr_q <= 12'h000;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= OKAY;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= OKAY;
      s_axi_rdata <= 32'h0000_0000;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_full_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_full_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (do_wr) begin
        aw_full_q <= 1'b0;
        w_full_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= mapped(aw_addr_q) ? OKAY : SLVERR;
      end else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= reg_view(s_axi_araddr);
        s_axi_rresp <= mapped(s_axi_araddr) ? OKAY : SLVERR;
      end else if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  // ****************************************************************
  // Control, alarm and value registers (power-on reset only)
  // ****************************************************************
  always @(posedge clk_sys) begin
    if (!nrst) begin
      cal_q <= 10'h000;
      on_q <= 1'b0;
      idle_halt_q <= 1'b0;
      psel_q <= 1'b0;
      unlock_q <= 1'b0;
      oe_q <= 1'b0;
      arm_q <= 1'b0;
      chime_q <= 1'b0;
      piv_q <= 1'b0;
      pulse_q <= 1'b0;
      ivl_q <= 4'h0;
      rpt_q <= 8'h00;
      time_q <= `BCC_TIME_RST;
      date_q <= `BCC_DATE_RST;
      atime_q <= `BCC_TIME_RST;
      adate_q <= `BCC_DATE_RST;
      tick_d_q <= 1'b0;
      htick_d_q <= 1'b0;
      chk_q <= 1'b0;
      alarm_event <= 1'b0;
      rtc_pin_o <= 1'b0;
      rtc_pin_oe <= 1'b0;
    end else begin
      tick_d_q <= sec_tick & on_q;
      htick_d_q <= half_tick & on_q;
      chk_q <= 1'b0;
      alarm_event <= fire;
      // Hardware alarm event first; a same-cycle software write overrides
      if (fire) begin
        pulse_q <= ~pulse_q;
        if (rpt_q != 8'h00)
          rpt_q <= rpt_q - 8'h01;
        else if (chime_q)
          rpt_q <= 8'hFF;
        else
          arm_q <= 1'b0;
      end
      if (on_q && sec_tick) begin
        time_q <= time_nx;
        date_q <= date_nx;
      end
      if (wr_ctrl) begin
        cal_q <= ctrl_nx[`BCC_CAL_LSB +: 10];
        idle_halt_q <= ctrl_nx[`BCC_IDLE_BIT];
        psel_q <= ctrl_nx[`BCC_PSEL_BIT];
        oe_q <= ctrl_nx[`BCC_OE_BIT];
        if (unlock_q)
          on_q <= ctrl_nx[`BCC_ON_BIT];
        unlock_q <= ctrl_nx[`BCC_UNLOCK_BIT] & (unlock_q | wr_seq_ok);
      end
      if (wr_alrm) begin
        arm_q <= alrm_nx[`BCC_ARM_BIT];
        chime_q <= alrm_nx[`BCC_CHIME_BIT];
        piv_q <= alrm_nx[`BCC_PIV_BIT];
        pulse_q <= alrm_nx[`BCC_PIV_BIT];
        ivl_q <= alrm_nx[`BCC_IVL_LSB +: 4];
        rpt_q <= alrm_nx[7:0];
      end
      if (wr_time)
        time_q <= apply(time_q, w_data_q, wop, `BCC_TIME_WMASK & lanes);
      if (wr_date)
        date_q <= apply(date_q, w_data_q, wop, `BCC_DATE_WMASK & lanes);
      if (wr_ok && wbase == `BCC_ATIME_OFS)
        atime_q <= apply(atime_q, w_data_q, wop, `BCC_TIME_WMASK & lanes);
      if (wr_ok && wbase == `BCC_ADATE_OFS)
        adate_q <= apply(adate_q, w_data_q, wop, `BCC_ADATE_WMASK & lanes);
      // Pin: seconds clock or alarm pulse, only while output enabled
      rtc_pin_oe <= oe_q & on_q;
      rtc_pin_o <= oe_q & on_q & (psel_q ? ~half_flag : pulse_q);
    end
  end
endmodule // bcc_top
`default_nettype wire

// ### bcc_top_sva.sv
// Port checker for the clock-calendar unit
// Assumes binding onto bcc_top; one clock domain, clk_sys
`timescale 1ns/1ps
`default_nettype none
module bcc_top_sva #(
  parameter HALF_CNT = 16384
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // Write channels
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // Read channels
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Pin and alarm
  input wire logic rtc_pin_oe,
  input wire logic alarm_event
);
  wire logic hs = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  // ********************
  // Properties
  // ********************
  property p_bhold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_bhold: assert property (p_bhold) else $error("write response dropped early");
  property p_rhold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_rhold: assert property (p_rhold) else $error("read data dropped early");
  property p_wans;
    hs |-> ##[1:2] s_axi_bvalid;
  endproperty
  a_wans: assert property (p_wans) else $error("write response late");
  property p_rans;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_rans: assert property (p_rans) else $error("read data late");
  property p_busy;
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  a_busy: assert property (p_busy) else $error("new write taken during response");
  property p_slverr;
    hs && (s_axi_awaddr[11:4] < 8'h20 || s_axi_awaddr[11:4] > 8'h25)
      |-> ##[1:2] (s_axi_bvalid && s_axi_bresp == 2'b10);
  endproperty
  a_slverr: assert property (p_slverr) else $error("unmapped write not refused");
  property p_pulse;
    alarm_event |=> !alarm_event;
  endproperty
  a_pulse: assert property (p_pulse) else $error("alarm pulse too long");
  property p_oe_off;
    hs && s_axi_awaddr == 12'h204 && s_axi_wdata[0] && s_axi_wstrb[0] |-> ##[1:4] !rtc_pin_oe;
  endproperty
  a_oe_off: assert property (p_oe_off) else $error("pin still driven");
  property p_rst;
    disable iff (1'b0) !nrst |=> !s_axi_bvalid && !s_axi_rvalid && !alarm_event && !rtc_pin_oe;
  endproperty
  a_rst: assert property (p_rst) else $error("outputs active after reset");
endmodule // bcc_top_sva
bind bcc_top bcc_top_sva #(.HALF_CNT(HALF_CNT)) bcc_top_sva_inst (
  .clk_sys, .nrst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .rtc_pin_oe, .alarm_event
);
`default_nettype wire

// ### tb_bcc_top.sv
// Self-checking bench for the clock-calendar unit
// Assumes bcc_top with a shortened prescaler and the bound checker
`timescale 1ns/1ps
`default_nettype none
`include "bcc_map.vh"
module tb_bcc_top;
  logic clk_sys = 0;
  logic nrst = 0;
  logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0, cpu_idle = 0, wr_seq_ok = 0, xtal_clk = 0, xtal_run = 1, p;
  logic [31:0] s_axi_wdata = 0, e, r, seed = 32'h0000_68f8;
  logic [3:0] s_axi_wstrb = 0;
  wire logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire logic [1:0] s_axi_bresp, s_axi_rresp;
  wire logic [31:0] s_axi_rdata;
  wire logic rtc_pin_o, rtc_pin_oe, alarm_event;
  logic [31:0] rq[$], mq[$];
  logic [1:0] bq[$], rrq[$];
  logic [31:0] d_in[3] = '{32'h2402_2803, 32'h2312_3106, 32'h2302_2802};
  logic [31:0] d_out[3] = '{32'h2402_2904, 32'h2401_0100, 32'h2303_0103};
  int failures = 0, compares = 0, n_alarm = 0, a0;
  bcc_top #(.HALF_CNT(4)) bcc_top_inst (
    .clk_sys, .nrst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .cpu_idle, .wr_seq_ok, .xtal_clk, .rtc_pin_o, .rtc_pin_oe, .alarm_event
  );
  initial begin
    forever #20 clk_sys = ~clk_sys;
  end
  // Crystal stands still while stopped
  initial begin
    forever begin
      #200;
      if (xtal_run) xtal_clk = ~xtal_clk;
    end
  end
  // ********************
  // Tasks
  // ********************
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s = 4'hf,
                    input logic [1:0] er = 2'b00);
    bit ad = 0;
    bit dd = 0;
    bq.push_back(er);
    seed = lfsr(seed);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (!ad && s_axi_awready) begin
        ad = 1;
        s_axi_awvalid <= 1'b0;
      end
      if (!dd && s_axi_wready) begin
        dd = 1;
        s_axi_wvalid <= 1'b0;
      end
    end while (!(ad && dd));
    repeat (seed[1:0]) @(posedge clk_sys);
    s_axi_bready <= 1'b1;
    do @(posedge clk_sys); while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] ex, input logic [31:0] m = '1,
                    input logic [1:0] er = 2'b00);
    rrq.push_back(er);
    rq.push_back(ex & m);
    mq.push_back(m);
    seed = lfsr(seed);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge clk_sys); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    repeat (seed[1:0]) @(posedge clk_sys);
    s_axi_rready <= 1'b1;
    do @(posedge clk_sys); while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic give_verdict;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // Result watcher takes the oldest note per answer
  always @(posedge clk_sys) begin
    if (s_axi_bvalid && s_axi_bready) check({30'b0, s_axi_bresp}, {30'b0, bq.pop_front()});
    if (s_axi_rvalid && s_axi_rready) check(s_axi_rdata & mq.pop_front(), rq.pop_front());
    if (s_axi_rvalid && s_axi_rready) check({30'b0, s_axi_rresp}, {30'b0, rrq.pop_front()});
    if (alarm_event) n_alarm <= n_alarm + 1;
  end
  initial begin
    repeat (8000) @(posedge clk_sys);
    failures++;
    give_verdict();
  end
  // ********************
  // Tests
  // ********************
  initial begin
    repeat (6) @(posedge clk_sys);
    nrst <= 1'b1;
    rd(12'h200, 32'h0, ~32'h46);
    rd(12'h210, 32'h0, ~32'h1000);
    rd(12'h230, `BCC_DATE_RST);
    wr(12'h300, 32'h1, 4'hf, 2'b10);
    rd(12'h300, 32'h0, '1, 2'b10);
    wr(12'h220, 32'h1234_5600);
    rd(12'h220, `BCC_TIME_RST);
    wr(12'h208, 32'h0000_8008);
    rd(12'h200, 32'h0, 32'h0000_8008);
    wr_seq_ok <= 1'b1;
    wr(12'h208, 32'h0000_0008);
    wr_seq_ok <= 1'b0;
    wr(12'h208, 32'h0000_8081);
    rd(12'h200, 32'h0000_8089, `BCC_CTRL_WMASK);
    check({31'b0, rtc_pin_oe}, 32'h1);
    $display("test reset and unlock done");
    e = seed & `BCC_TIME_WMASK;
    wr(12'h240, seed);
    rd(12'h240, e);
    for (int op = 1; op < 4; op++) begin
      r = seed & `BCC_TIME_WMASK;
      e = (op == 1) ? e & ~r : (op == 2) ? e | r : e ^ r;
      wr(12'h240 | 12'(op << 2), seed);
      rd(12'h240, e);
    end
    $display("test companions done");
    for (int i = 0; i < 3; i++) begin
      wr(12'h230, d_in[i]);
      wr(12'h220, 32'h2359_5900, 4'hf);
      repeat (4) @(posedge clk_sys);
      rd(12'h200, 32'h0, 32'h6);
      check({31'b0, rtc_pin_o}, 32'h1);
      repeat (32) @(posedge clk_sys);
      rd(12'h200, 32'h6, 32'h6);
      check({31'b0, rtc_pin_o}, 32'h0);
      repeat (50) @(posedge clk_sys);
      rd(12'h220, 32'h0);
      rd(12'h230, d_out[i]);
    end
    $display("test rollover done");
    wr(12'h208, 32'h0000_2000);
    cpu_idle <= 1'b1;
    repeat (2) @(posedge clk_sys);
    check({31'b0, s_axi_awready}, 32'h0);
    cpu_idle <= 1'b0;
    @(posedge clk_sys);
    check({31'b0, s_axi_awready}, 32'h1);
    @(posedge rtc_pin_o);
    @(posedge clk_sys);
    wr(12'h204, 32'h0000_2080);
    a0 = n_alarm;
    wr(12'h210, 32'h0000_8101);
    repeat (400) @(posedge clk_sys);
    check(32'(n_alarm - a0), 32'h2);
    rd(12'h210, 32'h0000_0100, ~32'h1000);
    a0 = n_alarm;
    wr(12'h210, 32'h0000_C000);
    for (int k = 0; k < 2; k++) begin
      do @(posedge clk_sys); while (!alarm_event);
      p = rtc_pin_o;
      repeat (3) @(posedge clk_sys);
      check({31'b0, rtc_pin_o}, {31'b0, ~p});
      rd(12'h210, 32'h0000_C100 - 32'(n_alarm - a0), ~32'h1000);
    end
    $display("test alarm done");
    wr(12'h210, 32'h0);
    wr(12'h204, 32'h0000_0001);
    check({31'b0, rtc_pin_oe}, 32'h0);
    check({31'b0, rtc_pin_o}, 32'h0);
    xtal_run = 0;
    repeat (2200) @(posedge clk_sys);
    rd(12'h200, 32'h0, 32'h40);
    xtal_run = 1;
    repeat (100) @(posedge clk_sys);
    rd(12'h200, 32'h40, 32'h40);
    $display("test pin and crystal done");
    give_verdict();
  end
endmodule // tb_bcc_top
`default_nettype wire
